// ---- tb/uhr_hub_core_asserts.sv ----
/*
 * checker of the hub core port behaviour, bound to uhr_hub_core.
 * assumes one core clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module uhr_hub_core_asserts #(
	parameter int BLINK_HALF_CYCLES = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_self_bus,
	input wire logic i_local_supply_sense,
	input wire logic [3:0] i_port_overcurrent_n,
	input wire logic [3:0] i_port_enable,
	input wire logic [3:0] i_set_port_power,
	input wire logic [3:0] i_clear_port_power,
	input wire logic i_clear_port_power_all,
	input wire logic [3:0] i_clear_ovc_change,
	input wire logic i_reenumerate,
	input wire logic [3:0] o_port_power_switch_n,
	input wire logic [3:0] o_port_status_n,
	input wire logic [3:0] o_port_ovc_status,
	input wire logic [3:0] o_port_ovc_change,
	input wire logic o_upstream_oe,
	input wire logic [3:0] o_downstream_oe,
	input wire logic o_self_powered,
	input wire logic o_local_power_good,
	input wire logic [13:0] o_frame_count,
	input wire logic o_sof_seen
);
	// ****************
	// helper state
	// ****************
	logic [2:0] age;
	logic [1:0] seen;
	logic arm, arm_d, prev_st, chg;
	logic [31:0] cnt;
	assign chg = o_port_status_n[0] != prev_st;
	// age since reset, blink arming and lamp change spacing of port 0
	always_ff @(posedge i_core_clk) begin
		prev_st <= o_port_status_n[0];
		if (i_rst) begin
			age <= 3'h0;
			arm <= 1'b0;
			arm_d <= 1'b0;
			seen <= 2'h0;
			cnt <= 32'h0;
		end else begin
			if (age != 3'h7)
				age <= age + 3'h1;
			arm_d <= arm;
			if (i_clear_port_power[0] | i_clear_port_power_all | i_reenumerate)
				arm <= 1'b0;
			else if (o_port_ovc_status[0])
				arm <= 1'b1;
			cnt <= chg ? 32'h0 : cnt + 32'h1;
			if (!arm)
				seen <= 2'h0;
			else if (chg && seen != 2'h3)
				seen <= seen + 2'h1;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence no_ovc_s;
		i_port_overcurrent_n[0] [*8];
	endsequence
	sequence set_only_s;
		i_set_port_power[0] && !i_clear_port_power[0] &&
			!i_clear_port_power_all && !i_reenumerate;
	endsequence
	// ****************
	// assertions
	// ****************
	reset_out_a: assert property (disable iff (1'b0) i_rst |=>
		o_port_power_switch_n == 4'hF && o_port_status_n == 4'hF &&
		o_port_ovc_change == 4'h0 && o_downstream_oe == 4'h0 && !o_upstream_oe)
		else $error("outputs not idle after reset");
	clear_all_a: assert property (i_clear_port_power_all |=>
		o_port_power_switch_n == 4'hF) else $error("power kept after clear");
	power_on_set_a: assert property (no_ovc_s ##0 set_only_s |=>
		!o_port_power_switch_n[0]) else $error("power not applied");
	ovc_off_a: assert property (!i_port_overcurrent_n[0] [*7] |->
		o_port_power_switch_n[0] && o_port_ovc_status[0])
		else $error("power kept during overcurrent");
	change_hold_a: assert property (o_port_ovc_change[0] &&
		!i_clear_ovc_change[0] |=> o_port_ovc_change[0])
		else $error("change flag lost");
	lamp_state_a: assert property (!arm && !arm_d && age == 3'h7 &&
		$stable(i_port_enable[0]) && $stable(o_port_power_switch_n[0]) |->
		o_port_status_n[0] == !(i_port_enable[0] && !o_port_power_switch_n[0]))
		else $error("lamp does not follow port state");
	blink_gap_a: assert property (arm && seen == 2'h3 && chg |->
		cnt == BLINK_HALF_CYCLES - 1) else $error("blink half period wrong");
	self_mode_a: assert property ((age == 3'h7 && $stable(i_self_bus)) [*5] |->
		o_self_powered == i_self_bus) else $error("power mode wrong");
	local_sense_a: assert property ((age == 3'h7 && $stable(i_self_bus) &&
		$stable(i_local_supply_sense)) [*5] |->
		o_local_power_good == (i_self_bus && i_local_supply_sense))
		else $error("local supply report wrong");
	sof_zero_a: assert property (o_sof_seen |-> ##[0:3]
		o_frame_count == 14'h0000) else $error("frame timer not cleared");
	frame_max_a: assert property (o_frame_count <= 14'h2EDF)
		else $error("frame timer past end");
endmodule // uhr_hub_core_asserts
bind uhr_hub_core uhr_hub_core_asserts #(
	.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_chk (.i_core_clk, .i_rst, .i_self_bus, .i_local_supply_sense,
	.i_port_overcurrent_n, .i_port_enable, .i_set_port_power,
	.i_clear_port_power, .i_clear_port_power_all, .i_clear_ovc_change,
	.i_reenumerate, .o_port_power_switch_n, .o_port_status_n,
	.o_port_ovc_status, .o_port_ovc_change, .o_upstream_oe, .o_downstream_oe,
	.o_self_powered, .o_local_power_good, .o_frame_count, .o_sof_seen);
`default_nettype wire

// ---- tb/uhr_hub_core_bench.sv ----
/*
 * self-checking bench of the hub core with a short blink period.
 * assumes the partner model and the bound checker are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; \
	if ((a) !== (b)) begin failures++; \
	$display("mismatch %0t %s", $time, m); end end
module uhr_hub_core_bench;
	typedef struct packed {
		logic [3:0] set, clr;
		logic all;
		logic [3:0] en, pwr, st;
	} uhr_row_s;
	logic clk = 0, rst = 1, self_bus = 1, lps = 1, all = 0, reen = 0;
	logic [3:0] ovc_n = 4'hF, en = 0, setp = 0, clrp = 0, clrc = 0;
	logic up_oe, up_dpo, up_dmo, up_dp, up_dm, selfp, lgood, sof, clr_seen;
	logic [3:0] ds_oe, ds_dpo, ds_dmo, ds_dp, ds_dm, pwr_n, st_n, ovs, ovch;
	logic [3:0] ls, conn, seen_ds;
	logic seen_up, seen_sof;
	logic [13:0] fc, f0;
	int failures = 0, comparisons = 0, cyc = 0, n;
	uhr_row_s rows [5] = '{'{4'hF, 4'h0, 0, 4'h0, 4'h0, 4'hF},
		'{4'h0, 4'h0, 0, 4'h5, 4'h0, 4'hA}, '{4'h0, 4'h1, 0, 4'h5, 4'h1, 4'hB},
		'{4'h0, 4'h0, 1, 4'h5, 4'hF, 4'hF}, '{4'h6, 4'h0, 0, 4'hF, 4'h9, 4'h9}};
	always #10 clk = ~clk;
	uhr_hub_core #(.BLINK_HALF_CYCLES(8)) DUT (.i_core_clk(clk), .i_rst(rst),
		.i_self_bus(self_bus), .i_local_supply_sense(lps),
		.i_upstream_dplus(up_dp), .i_upstream_dminus(up_dm),
		.o_upstream_dplus(up_dpo), .o_upstream_dminus(up_dmo),
		.o_upstream_oe(up_oe), .i_downstream_dplus(ds_dp),
		.i_downstream_dminus(ds_dm), .o_downstream_dplus(ds_dpo),
		.o_downstream_dminus(ds_dmo), .o_downstream_oe(ds_oe),
		.i_port_overcurrent_n(ovc_n), .o_port_power_switch_n(pwr_n),
		.o_port_status_n(st_n), .i_port_enable(en), .i_set_port_power(setp),
		.i_clear_port_power(clrp), .i_clear_port_power_all(all),
		.i_clear_ovc_change(clrc), .i_reenumerate(reen),
		.o_port_ovc_status(ovs), .o_port_ovc_change(ovch),
		.o_port_low_speed(ls), .o_port_connected(conn), .o_self_powered(selfp),
		.o_local_power_good(lgood), .o_frame_count(fc), .o_sof_seen(sof),
		.o_pid_error());
	uhr_usb_partner partner (.i_up_oe(up_oe), .i_up_dp(up_dpo),
		.i_up_dm(up_dmo), .i_ds_oe(ds_oe), .i_ds_dp(ds_dpo), .i_ds_dm(ds_dmo),
		.o_up_dp(up_dp), .o_up_dm(up_dm), .o_ds_dp(ds_dp), .o_ds_dm(ds_dm));
	// sticky record of drives and frame starts seen during a packet
	always @(posedge clk) begin
		if (clr_seen) begin
			seen_ds <= 4'h0;
			seen_up <= 1'b0;
			seen_sof <= 1'b0;
		end else begin
			seen_ds <= seen_ds | ds_oe;
			seen_up <= seen_up | up_oe;
			seen_sof <= seen_sof | sof;
		end
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic pulse(input logic [3:0] s, c, cc, input logic a, r);
		{setp, clrp, clrc, all, reen} = {s, c, cc, a, r};
		step(1);
		{setp, clrp, clrc, all, reen} = 0;
	endtask
	// cycles between two lamp changes of port 0
	task automatic gap(output int g);
		logic s;
		s = st_n[0];
		for (g = 0; g < 40 && st_n[0] === s; g++) step(1);
		s = st_n[0];
		for (g = 0; g < 40 && st_n[0] === s; g++) step(1);
	endtask
	task automatic complete_run();
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		clr_seen = 1;
		step(8);
		`CHK({pwr_n, st_n, ovch}, 12'hFF0, "reset outputs")
		rst = 0;
		for (int m = 0; m < 2; m++) begin
			self_bus = m[0];
			step(6);
			`CHK(selfp, m[0], "power mode")
			`CHK(lgood, m[0], "local supply")
		end
		foreach (rows[i]) begin
			en = rows[i].en;
			pulse(rows[i].set, rows[i].clr, 4'h0, rows[i].all, 1'b0);
			step(2);
			`CHK({pwr_n, st_n}, {rows[i].pwr, rows[i].st}, "power row")
		end
		`CHK({conn, ls}, 8'h32, "speed detect")
		en = 4'h3;
		pulse(4'hF, 4'h0, 4'h0, 1'b0, 1'b0);
		clr_seen = 0;
		partner.send(0, 8'hA5);
		f0 = fc;
		`CHK({seen_ds, seen_sof}, 5'h03, "downstream repeat")
		`CHK(f0 < 14'h0010, 1'b1, "frame start")
		step(500);
		`CHK(fc - f0 > 14'h0075 && fc - f0 < 14'h007B, 1'b1, "bit rate")
		clr_seen = 1;
		step(1);
		clr_seen = 0;
		partner.send(0, 8'h3C);
		`CHK(seen_ds, 4'h3, "preamble repeat")
		step(5);
		`CHK(ds_oe, 4'h0, "drivers off")
		partner.send(1, 8'hE1);
		`CHK(seen_up, 1'b1, "upstream repeat")
		ovc_n = 4'hE;
		step(6);
		`CHK({pwr_n[0], ovs, ovch}, 9'h111, "overcurrent")
		pulse(4'h1, 4'h0, 4'h0, 1'b0, 1'b0);
		step(2);
		`CHK(pwr_n[0], 1'b1, "set refused")
		gap(n);
		`CHK(n, 8, "blink")
		ovc_n = 4'hF;
		step(8);
		`CHK({ovs, ovch}, 8'h01, "sticky change")
		gap(n);
		`CHK(n, 8, "blink after release")
		pulse(4'h0, 4'h0, 4'h1, 1'b0, 1'b0);
		step(1);
		`CHK(ovch, 4'h0, "change cleared")
		pulse(4'h0, 4'h1, 4'h0, 1'b0, 1'b0);
		step(2);
		for (int i = 0; i < 20; i++) begin
			step(1);
			`CHK(st_n[0], 1'b1, "blink stop")
		end
		ovc_n = 4'hB;
		step(20);
		ovc_n = 4'hF;
		pulse(4'h0, 4'h0, 4'h0, 1'b0, 1'b1);
		step(2);
		for (int i = 0; i < 20; i++) begin
			step(1);
			`CHK({st_n[2], pwr_n[2]}, 2'h3, "re-enumerated")
		end
		rst = 1;
		step(2);
		`CHK({pwr_n, st_n}, 8'hFF, "second reset")
		complete_run();
	end
endmodule // uhr_hub_core_bench
`default_nettype wire

// ---- tb/uhr_usb_partner.sv ----
/*
 * host on the upstream port and devices on the downstream ports.
 * assumes the hub's drive values and enables; resolves each line.
 */
`timescale 1ns/1ps
`default_nettype none
module uhr_usb_partner (
	input wire logic i_up_oe,
	input wire logic i_up_dp,
	input wire logic i_up_dm,
	input wire logic [3:0] i_ds_oe,
	input wire logic [3:0] i_ds_dp,
	input wire logic [3:0] i_ds_dm,
	output logic o_up_dp,
	output logic o_up_dm,
	output logic [3:0] o_ds_dp,
	output logic [3:0] o_ds_dm
);
	// host idles in J; port 0 full speed, port 1 low speed, rest pulled low
	logic h_dp = 1'b1;
	logic h_dm = 1'b0;
	logic [3:0] d_dp = 4'h1;
	logic [3:0] d_dm = 4'h2;
	// a driving hub wins the line, otherwise the far side level shows
	assign o_up_dp = i_up_oe ? i_up_dp : h_dp;
	assign o_up_dm = i_up_oe ? i_up_dm : h_dm;
	assign o_ds_dp = (i_ds_oe & i_ds_dp) | (~i_ds_oe & d_dp);
	assign o_ds_dm = (i_ds_oe & i_ds_dm) | (~i_ds_oe & d_dm);
	// one line state from the host or from the full speed device
	task automatic put(input bit dev, input logic p, input logic m);
		if (dev)
			{d_dp[0], d_dm[0]} = {p, m};
		else
			{h_dp, h_dm} = {p, m};
	endtask
	// full speed packet: sync, pid, four data ones, then eop and idle
	task automatic send(input bit dev, input logic [7:0] pid);
		logic [19:0] b;
		logic lv;
		b = {4'hF, pid, 8'h80};
		lv = 1'b1;
		for (int i = 0; i < 20; i++) begin
			if (!b[i])
				lv = !lv;
			put(dev, lv, !lv);
			#83.333;
		end
		put(dev, 1'b0, 1'b0);
		#166.667;
		put(dev, 1'b1, 1'b0);
		#83.333;
	endtask
endmodule // uhr_usb_partner
`default_nettype wire

// ---- verilog/uhr_defines.svh ----
/*
 * constants of the hub repeater and port power logic.
 * assumes a 50 MHz core clock; included by bare name.
 */
`ifndef UHR_DEFINES_SVH
`define UHR_DEFINES_SVH

`define UHR_PORTS 4
// core clock and bit rate
`define UHR_CLK_PERIOD_NS 20
`define UHR_CLK_MHZ 6'h32
`define UHR_BIT_MHZ 6'h0C
`define UHR_ACC_MID 6'h19
// synchronised line vector layout
`define UHR_LN_USDP 0
`define UHR_LN_USDM 1
`define UHR_LN_DSDP 2
`define UHR_LN_DSDM 6
`define UHR_LN_SELF 10
`define UHR_LN_LPS 11
`define UHR_LN_W 12
// packet decoding
`define UHR_PID_PRE 8'h3C
`define UHR_PID_SOF 8'hA5
`define UHR_PID_DONE 5'h10
`define UHR_STUFF_ONES 3'h6
`define UHR_LS_ON_BITS 3'h2
`define UHR_FRAME_LAST 14'h2EDF
// disconnect: least time of single-ended zero
`define UHR_DISC_NS 2500
`define UHR_DISC_CYC ((`UHR_DISC_NS + `UHR_CLK_PERIOD_NS - 1) / `UHR_CLK_PERIOD_NS)
// overcurrent blink: full period in ns and half period in cycles
`define UHR_BLINK_PERIOD_NS 1000000000
`define UHR_BLINK_HALF_CYC ((`UHR_BLINK_PERIOD_NS / 2) / `UHR_CLK_PERIOD_NS)

`endif

// ---- verilog/uhr_hub_core.sv ----
/*
 * four port hub repeater with per port power management.
 * assumes a 50 MHz core clock, analog transceivers outside that
 * resolve the data pins from the output enables, and a hub
 * controller that issues port requests as one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uhr_defines.svh"

// Behaviour
// (RULE1) power-source select high means self powered, low bus powered
// (RULE2) local supply sense reported only when self powered
// (RULE3) upstream packets go to enabled ports; port packets go upstream
// (RULE4) attached device speed from which data line is high
// (RULE5) low-speed ports get traffic only after a preamble
// (RULE6) low-speed drivers on within four bits of preamble, off at EOP
// (RULE7) upstream port always sends with full-speed signalling
// (RULE8) every port drives and watches its lines for J, K and SE0
// (RULE9) frame timer on the bit clock, reset by each SOF token
// (RULE10) recover clock, undo NRZI and stuffing, decode and check PID
// (RULE11) downstream ports carry both 12 Mb/s and 1.5 Mb/s traffic
// (RULE12) bit rate derived from a faster internal clock
// (RULE13) overcurrent sets port overcurrent and change flags
// (RULE14) overcurrent removes port power at once
// (RULE15) overcurrent blinks the status lamp with a one second period
// (RULE16) status lamp lit while the port is enabled; the code also requires port power on
// (RULE17) port power only after a host set-power request
// (RULE18) power off at power-up, reset, overcurrent, host clear
// (RULE19) status lamp defaults off and goes off when port disabled
// (RULE20) blinking lasts until host removes power or re-enumerates
// (RULE21) overcurrent inputs are synchronised before use
module uhr_hub_core #(
	parameter int BLINK_HALF_CYCLES = `UHR_BLINK_HALF_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_self_bus,
	input wire logic i_local_supply_sense,
	input wire logic i_upstream_dplus,
	input wire logic i_upstream_dminus,
	output logic o_upstream_dplus,
	output logic o_upstream_dminus,
	output logic o_upstream_oe,
	input wire logic [3:0] i_downstream_dplus,
	input wire logic [3:0] i_downstream_dminus,
	output logic [3:0] o_downstream_dplus,
	output logic [3:0] o_downstream_dminus,
	output logic [3:0] o_downstream_oe,
	input wire logic [3:0] i_port_overcurrent_n,
	output logic [3:0] o_port_power_switch_n,
	output logic [3:0] o_port_status_n,
	input wire logic [3:0] i_port_enable,
	input wire logic [3:0] i_set_port_power,
	input wire logic [3:0] i_clear_port_power,
	input wire logic i_clear_port_power_all,
	input wire logic [3:0] i_clear_ovc_change,
	input wire logic i_reenumerate,
	output logic [3:0] o_port_ovc_status,
	output logic [3:0] o_port_ovc_change,
	output logic [3:0] o_port_low_speed,
	output logic [3:0] o_port_connected,
	output logic o_self_powered,
	output logic o_local_power_good,
	output logic [13:0] o_frame_count,
	output logic o_sof_seen,
	output logic o_pid_error
);
	// ********************************************************
	// declarations and line decoding helpers
	// ********************************************************

	logic [`UHR_LN_W-1:0] s1, s2, s3, line;
	logic [`UHR_LN_W-1:0] next_s1, next_s2, next_s3, next_line;
	logic next_self_powered, next_local_power_good;
	logic us_dp, us_dm;
	logic [3:0] ds_dp, ds_dm;
	logic [3:0] next_low, next_conn, act;
	logic [7:0] disc_cnt [4];
	logic [7:0] next_disc_cnt [4];
	uhr_pkg::uhr_rep_e state, next_state;
	logic [1:0] src, next_src;
	logic se0_seen, next_se0_seen;
	logic next_us_dp, next_us_dm, next_us_oe;
	logic [3:0] next_ds_dp, next_ds_dm, next_ds_oe, hit;
	logic [5:0] acc, next_acc;
	logic [6:0] acc_sum;
	logic tick, nrzi_prev, next_nrzi_prev, last_dp, rx_bit;
	logic [2:0] ones, next_ones, ls_cnt, next_ls_cnt;
	logic [4:0] bitcnt, next_bitcnt;
	logic [7:0] pid, next_pid;
	logic ls_run, next_ls_run, ls_gate, next_ls_gate;
	logic [13:0] next_frame_count;
	logic next_sof_seen, next_pid_error;

	// K state in the polarity of the port speed
	function automatic logic is_k(input logic dp, input logic dm,
		input logic low);
		return low ? (dp & ~dm) : (~dp & dm);
	endfunction

	// J state in the polarity of the port speed
	function automatic logic is_j(input logic dp, input logic dm,
		input logic low);
		return low ? (~dp & dm) : (dp & ~dm);
	endfunction

	// lowest numbered requesting port
	function automatic logic [1:0] first_port(input logic [3:0] req);
		logic [1:0] p;
		p = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			if (req[k]) begin
				p = 2'(k);
			end
		end
		return p;
	endfunction

	// ********************************************************
	// input synchronisers and power mode
	// ********************************************************

	// three flops, a change counts once stages two and three agree
	always_comb begin
		next_s1 = {i_local_supply_sense, i_self_bus, i_downstream_dminus,
			i_downstream_dplus, i_upstream_dminus, i_upstream_dplus};
		next_s2 = s1;
		next_s3 = s2;
		next_line = ((s2 ^ s3) & line) | (~(s2 ^ s3) & s3);
		next_self_powered = line[`UHR_LN_SELF]; // RULE1
		next_local_power_good = line[`UHR_LN_SELF] &
			line[`UHR_LN_LPS]; // RULE2
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			line <= '0;
			o_self_powered <= 1'b0;
			o_local_power_good <= 1'b0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
			line <= next_line;
			o_self_powered <= next_self_powered;
			o_local_power_good <= next_local_power_good;
		end
	end

	assign us_dp = line[`UHR_LN_USDP];
	assign us_dm = line[`UHR_LN_USDM];
	assign ds_dp = line[`UHR_LN_DSDP +: `UHR_PORTS];
	assign ds_dm = line[`UHR_LN_DSDM +: `UHR_PORTS];

	// ********************************************************
	// per port connect, speed and power
	// ********************************************************

	genvar gi;
	generate
		for (gi = 0; gi < `UHR_PORTS; gi++) begin : g_port
			// connect on first non-SE0 idle, drop after long SE0
			always_comb begin
				next_low[gi] = o_port_low_speed[gi];
				next_conn[gi] = o_port_connected[gi];
				next_disc_cnt[gi] = 8'h0;
				if (~ds_dp[gi] & ~ds_dm[gi]) begin
					next_disc_cnt[gi] = disc_cnt[gi] + 8'h1;
					if (disc_cnt[gi] >= 8'(`UHR_DISC_CYC - 1)) begin
						next_disc_cnt[gi] = disc_cnt[gi];
						next_conn[gi] = 1'b0;
					end
				end else if (~o_port_connected[gi]) begin
					next_conn[gi] = 1'b1;
					next_low[gi] = ds_dm[gi]; // RULE4 RULE11
				end
			end

			always_ff @(posedge i_core_clk) begin
				if (i_rst) begin
					disc_cnt[gi] <= 8'h0;
					o_port_low_speed[gi] <= 1'b0;
					o_port_connected[gi] <= 1'b0;
				end else begin
					disc_cnt[gi] <= next_disc_cnt[gi];
					o_port_low_speed[gi] <= next_low[gi];
					o_port_connected[gi] <= next_conn[gi];
				end
			end

			uhr_port_power #(
				.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
			) u_power (
				.i_core_clk(i_core_clk),
				.i_rst(i_rst),
				.i_overcurrent_n(i_port_overcurrent_n[gi]),
				.i_set_power(i_set_port_power[gi]),
				.i_clear_power(i_clear_port_power[gi] |
					i_clear_port_power_all), // RULE18
				.i_enable(i_port_enable[gi]),
				.i_clear_change(i_clear_ovc_change[gi]),
				.i_reenumerate(i_reenumerate),
				.o_power_switch_n(o_port_power_switch_n[gi]),
				.o_status_n(o_port_status_n[gi]),
				.o_ovc_status(o_port_ovc_status[gi]),
				.o_ovc_change(o_port_ovc_change[gi])
			);
		end
	endgenerate

	// a port takes part in repeating when enabled, powered, attached
	assign act = i_port_enable & ~o_port_power_switch_n & o_port_connected;

	// ********************************************************
	// repeater direction and line drive
	// ********************************************************

	always_comb begin
		next_state = state;
		next_src = src;
		next_se0_seen = se0_seen;
		next_us_dp = o_upstream_dplus;
		next_us_dm = o_upstream_dminus;
		next_us_oe = 1'b0;
		next_ds_dp = o_downstream_dplus;
		next_ds_dm = o_downstream_dminus;
		next_ds_oe = 4'h0;
		for (int k = 0; k < `UHR_PORTS; k++) begin
			hit[k] = act[k] & is_k(ds_dp[k], ds_dm[k],
				o_port_low_speed[k]); // RULE8
		end
		case (state)
			uhr_pkg::UHR_IDLE: begin
				next_se0_seen = 1'b0;
				if (is_k(us_dp, us_dm, 1'b0)) begin // RULE8
					next_state = uhr_pkg::UHR_DOWN;
				end else if (|hit) begin
					next_state = uhr_pkg::UHR_UP;
					next_src = first_port(hit);
				end
			end
			uhr_pkg::UHR_DOWN: begin
				// fan out, low-speed ports only behind a preamble
				for (int k = 0; k < `UHR_PORTS; k++) begin
					if (act[k] & (~o_port_low_speed[k] | ls_gate)) begin // RULE3 RULE5
						next_ds_oe[k] = 1'b1;
						next_ds_dp[k] = o_port_low_speed[k] ? us_dm : us_dp;
						next_ds_dm[k] = o_port_low_speed[k] ? us_dp : us_dm;
					end
				end
				if (~us_dp & ~us_dm) begin
					next_se0_seen = 1'b1; // RULE8
				end
				if (se0_seen & is_j(us_dp, us_dm, 1'b0)) begin
					next_state = uhr_pkg::UHR_IDLE;
				end
			end
			uhr_pkg::UHR_UP: begin
				// full-speed polarity toward the host
				next_us_oe = 1'b1; // RULE3
				next_us_dp = o_port_low_speed[src] ? ds_dm[src] :
					ds_dp[src]; // RULE7
				next_us_dm = o_port_low_speed[src] ? ds_dp[src] :
					ds_dm[src]; // RULE7
				if (~ds_dp[src] & ~ds_dm[src]) begin
					next_se0_seen = 1'b1;
				end
				if ((se0_seen & is_j(ds_dp[src], ds_dm[src],
					o_port_low_speed[src])) | ~act[src]) begin
					next_state = uhr_pkg::UHR_IDLE;
				end
			end
			default: begin
				next_state = uhr_pkg::UHR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= uhr_pkg::UHR_IDLE;
			src <= 2'h0;
			se0_seen <= 1'b0;
			o_upstream_dplus <= 1'b1;
			o_upstream_dminus <= 1'b0;
			o_upstream_oe <= 1'b0;
			o_downstream_dplus <= 4'h0;
			o_downstream_dminus <= 4'h0;
			o_downstream_oe <= 4'h0;
		end else begin
			state <= next_state;
			src <= next_src;
			se0_seen <= next_se0_seen;
			o_upstream_dplus <= next_us_dp;
			o_upstream_dminus <= next_us_dm;
			o_upstream_oe <= next_us_oe;
			o_downstream_dplus <= next_ds_dp;
			o_downstream_dminus <= next_ds_dm;
			o_downstream_oe <= next_ds_oe;
		end
	end

	// ********************************************************
	// upstream packet decoder and frame timer
	// ********************************************************

	always_comb begin
		// fractional bit clock, re-centred on every line edge
		acc_sum = {1'b0, acc} + {1'b0, `UHR_BIT_MHZ}; // RULE12
		tick = acc_sum >= {1'b0, `UHR_CLK_MHZ};
		next_acc = tick ? 6'(acc_sum - {1'b0, `UHR_CLK_MHZ}) : acc_sum[5:0];
		if (us_dp != last_dp) begin
			next_acc = `UHR_ACC_MID; // RULE10
		end
		rx_bit = (us_dp == nrzi_prev); // RULE10
		next_nrzi_prev = nrzi_prev;
		next_ones = ones;
		next_bitcnt = bitcnt;
		next_pid = pid;
		next_sof_seen = 1'b0;
		next_pid_error = 1'b0;
		next_ls_run = ls_run;
		next_ls_cnt = ls_cnt;
		next_ls_gate = ls_gate;
		next_frame_count = o_frame_count;
		if (tick) begin
			next_frame_count = (o_frame_count == `UHR_FRAME_LAST) ? 14'h0 :
				o_frame_count + 14'h1; // RULE9
		end
		if (state != uhr_pkg::UHR_DOWN) begin
			next_nrzi_prev = 1'b1;
			next_ones = 3'h0;
			next_bitcnt = 5'h0;
			next_ls_run = 1'b0;
			next_ls_cnt = 3'h0;
			next_ls_gate = 1'b0; // RULE6
		end else if (tick) begin
			next_nrzi_prev = us_dp;
			if (ls_run) begin
				next_ls_cnt = ls_cnt + 3'h1;
				if (ls_cnt == `UHR_LS_ON_BITS) begin
					next_ls_gate = 1'b1; // RULE6
				end
			end
			if (ones == `UHR_STUFF_ONES) begin
				next_ones = 3'h0; // RULE10
			end else if (bitcnt < `UHR_PID_DONE) begin
				next_ones = rx_bit ? ones + 3'h1 : 3'h0;
				next_pid = {rx_bit, pid[7:1]}; // RULE10
				next_bitcnt = bitcnt + 5'h1;
				if (bitcnt == `UHR_PID_DONE - 5'h1) begin
					if (next_pid[7:4] != ~next_pid[3:0]) begin
						next_pid_error = 1'b1; // RULE10
					end else if (next_pid == `UHR_PID_PRE) begin
						next_ls_run = 1'b1; // RULE5
					end else if (next_pid == `UHR_PID_SOF) begin
						next_sof_seen = 1'b1;
						next_frame_count = 14'h0; // RULE9
					end
				end
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			acc <= 6'h0;
			last_dp <= 1'b1;
			nrzi_prev <= 1'b1;
			ones <= 3'h0;
			bitcnt <= 5'h0;
			pid <= 8'h0;
			ls_run <= 1'b0;
			ls_cnt <= 3'h0;
			ls_gate <= 1'b0;
			o_frame_count <= 14'h0;
			o_sof_seen <= 1'b0;
			o_pid_error <= 1'b0;
		end else begin
			acc <= next_acc;
			last_dp <= us_dp;
			nrzi_prev <= next_nrzi_prev;
			ones <= next_ones;
			bitcnt <= next_bitcnt;
			pid <= next_pid;
			ls_run <= next_ls_run;
			ls_cnt <= next_ls_cnt;
			ls_gate <= next_ls_gate;
			o_frame_count <= next_frame_count;
			o_sof_seen <= next_sof_seen;
			o_pid_error <= next_pid_error;
		end
	end
endmodule // uhr_hub_core
`default_nettype wire

// ---- verilog/uhr_pkg.sv ----
/*
 * types shared by the hub repeater files.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package uhr_pkg;
	// repeater direction, gray coded along idle-down-up
	typedef enum logic [1:0] {
		UHR_IDLE = 2'b00,
		UHR_DOWN = 2'b01,
		UHR_UP = 2'b11
	} uhr_rep_e;
endpackage
`default_nettype wire

// ---- verilog/uhr_port_power.sv ----
/*
 * power switch, overcurrent flags and status lamp of one port.
 * assumes host requests arrive as one-cycle pulses on i_core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uhr_defines.svh"

module uhr_port_power #(
	parameter int BLINK_HALF_CYCLES = `UHR_BLINK_HALF_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_overcurrent_n,
	input wire logic i_set_power,
	input wire logic i_clear_power,
	input wire logic i_enable,
	input wire logic i_clear_change,
	input wire logic i_reenumerate,
	output logic o_power_switch_n,
	output logic o_status_n,
	output logic o_ovc_status,
	output logic o_ovc_change
);
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic ovc;
	logic next_ovc;
	logic blinking;
	logic next_blinking;
	logic phase;
	logic next_phase;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_power_switch_n;
	logic next_status_n;
	logic next_ovc_status;
	logic next_ovc_change;
	logic ovc_rise;

	// ********************************************************
	// overcurrent sensing and power control
	// ********************************************************

	// three stage sync, level taken when stages two and three agree
	always_comb begin
		next_sync = {sync[1:0], ~i_overcurrent_n}; // RULE21
		next_ovc = (sync[1] == sync[2]) ? sync[2] : ovc; // RULE21
		ovc_rise = next_ovc & ~ovc;
		// overcurrent wins, then removal, then host power request
		next_power_switch_n = o_power_switch_n;
		if (next_ovc) begin
			next_power_switch_n = 1'b1; // RULE14 RULE18
		end else if (i_clear_power | i_reenumerate) begin
			next_power_switch_n = 1'b1; // RULE18
		end else if (i_set_power) begin
			next_power_switch_n = 1'b0; // RULE17
		end
		// flags: a new overcurrent beats a clear in the same cycle
		next_ovc_status = next_ovc; // RULE13
		next_ovc_change = ovc_rise | (o_ovc_change & ~i_clear_change); // RULE13
		next_blinking = ovc_rise |
			(blinking & ~i_clear_power & ~i_reenumerate); // RULE20
		// half period counter for the lamp square wave
		next_cnt = '0;
		next_phase = 1'b0;
		if (next_blinking) begin
			next_cnt = cnt + 32'h1;
			next_phase = phase;
			if (cnt >= 32'(BLINK_HALF_CYCLES - 1)) begin
				next_cnt = '0;
				next_phase = ~phase; // RULE15
			end
		end
		// lamp is active low: blink, else lit while the port is enabled and powered
		if (next_blinking) begin
			next_status_n = next_phase; // RULE15
		end else begin
			next_status_n = ~(i_enable & ~next_power_switch_n); // RULE16 RULE19
		end
	end

	// registers of the port power group
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sync <= '0;
			ovc <= 1'b0;
			blinking <= 1'b0;
			phase <= 1'b0;
			cnt <= '0;
			o_power_switch_n <= 1'b1; // RULE18
			o_status_n <= 1'b1; // RULE19
			o_ovc_status <= 1'b0;
			o_ovc_change <= 1'b0;
		end else begin
			sync <= next_sync;
			ovc <= next_ovc;
			blinking <= next_blinking;
			phase <= next_phase;
			cnt <= next_cnt;
			o_power_switch_n <= next_power_switch_n;
			o_status_n <= next_status_n;
			o_ovc_status <= next_ovc_status;
			o_ovc_change <= next_ovc_change;
		end
	end
endmodule // uhr_port_power
`default_nettype wire
